// ---- adcshp_pkg.sv ----
// Shared constants for the converter serial host port, both ends.
package adcshp_pkg;
  localparam int SYS_PERIOD_NS = 10;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int CS_GAP_CYC = SCLK_HALF_CYC;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MAIN_DATA = 4'h4;
  localparam logic [3:0] ADDR_AUX_DATA = 4'h5;
  localparam int COMM_RD_BIT = 6;
  localparam int COMM_BITS = 8;
  localparam int DATA_MAX_BITS = 24;
  localparam int STATUS_MAIN_BIT = 0;
  localparam int STATUS_AUX_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CMD_W = 34;
  localparam int CMD_DEPTH = 16;
  localparam logic [4:0] LEN_8 = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_24 = 5'h18;
endpackage

// ---- adcshp_if.sv ----
// Serial link between the converter port and its host.
`timescale 1ns/100ps
`default_nettype none
interface adcshp_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic misoOut;
  logic misoOeN;
  logic rdyN;
  logic misoLine;
  // The shared data line is pulled up while the device releases it.
  assign misoLine = misoOeN ? 1'b1 : misoOut;
  modport dev (input sclk, input csN, input mosi, output misoOut,
    output misoOeN, output rdyN, input misoLine);
  modport host (output sclk, output csN, output mosi, input misoLine,
    input rdyN);
endinterface
`default_nettype wire

// ---- adcshp_device.sv ----
// Device end: serial register port with result ready flags.
`timescale 1ns/100ps
`default_nettype none
module adcshp_device (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // synchronous reset, active low
  adcshp_if.dev link, // serial link
  input wire logic mainValid, // main result strobe
  input wire logic [23:0] mainData, // main result
  input wire logic auxValid, // aux result strobe
  input wire logic [15:0] auxData, // aux result
  output logic wrStrobe, // register written pulse
  output logic [3:0] wrAddr, // written register
  output logic [7:0] wrData, // written value
  output logic mainFlag, // main_result_ready_flag
  output logic auxFlag // aux_result_ready_flag
);
  typedef enum {ADCSHP_COMM, ADCSHP_WR, ADCSHP_RD} adcshp_phase_t;
  adcshp_phase_t phase_r;
  logic [2:0] sclkSync_r, csSync_r, dinSync_r;
  logic sclkLvl_r, csLvl_r;
  logic [4:0] bitCnt_r, len_r;
  logic [7:0] shiftIn_r;
  logic [23:0] shiftOut_r, mainHold_r;
  logic [15:0] auxHold_r;
  logic [3:0] addr_r;
  logic [7:0] regs_r [16];
  logic rise, fall, active, lastBit, rdMain, rdAux;
  logic [7:0] commByte;
  logic [4:0] lenNxt;
  logic [23:0] rdVal;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sclkSync_r <= 3'h7;
      csSync_r <= 3'h7;
      dinSync_r <= 3'h7;
    end else begin
      sclkSync_r <= {sclkSync_r[1:0], link.sclk};
      csSync_r <= {csSync_r[1:0], link.csN};
      dinSync_r <= {dinSync_r[1:0], link.mosi};
    end
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sclkLvl_r <= 1'b1;
      csLvl_r <= 1'b1;
    end else begin
      if (sclkSync_r[1] == sclkSync_r[2])
        sclkLvl_r <= sclkSync_r[2];
      if (csSync_r[1] == csSync_r[2])
        csLvl_r <= csSync_r[2];
    end
  end

  assign active = !csLvl_r;
  assign rise = active && (sclkSync_r[1] == sclkSync_r[2]) &&
    sclkSync_r[2] && !sclkLvl_r;
  assign fall = active && (sclkSync_r[1] == sclkSync_r[2]) &&
    !sclkSync_r[2] && sclkLvl_r;
  assign commByte = {shiftIn_r[6:0], dinSync_r[2]};
  assign lastBit = (bitCnt_r + 5'h01) == len_r;

  always_comb begin
    lenNxt = adcshp_pkg::LEN_8;
    rdVal = {regs_r[commByte[3:0]], 16'h0000};
    case (commByte[3:0])
      adcshp_pkg::ADDR_STATUS: begin
        rdVal = {6'h00, auxFlag, mainFlag, 16'h0000};
      end
      adcshp_pkg::ADDR_MAIN_DATA: begin
        lenNxt = adcshp_pkg::LEN_24;
        rdVal = mainHold_r;
      end
      adcshp_pkg::ADDR_AUX_DATA: begin
        lenNxt = adcshp_pkg::LEN_16;
        rdVal = {auxHold_r, 8'h00};
      end
      default: begin
        lenNxt = adcshp_pkg::LEN_8;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !active) begin
      phase_r <= ADCSHP_COMM;
      bitCnt_r <= 5'h00;
      len_r <= adcshp_pkg::LEN_8;
      addr_r <= 4'h0;
    end else if (rise) begin
      case (phase_r)
        ADCSHP_COMM: begin
          if (bitCnt_r == adcshp_pkg::LEN_8 - 5'h01) begin
            bitCnt_r <= 5'h00;
            addr_r <= commByte[3:0];
            len_r <= commByte[adcshp_pkg::COMM_RD_BIT] ? lenNxt :
              adcshp_pkg::LEN_8;
            phase_r <= commByte[adcshp_pkg::COMM_RD_BIT] ? ADCSHP_RD :
              ADCSHP_WR;
          end else begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
        default: begin
          if (lastBit) begin
            bitCnt_r <= 5'h00;
            len_r <= adcshp_pkg::LEN_8;
            phase_r <= ADCSHP_COMM;
          end else begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      shiftIn_r <= 8'h00;
    else if (rise && phase_r != ADCSHP_RD)
      shiftIn_r <= commByte;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wrStrobe <= 1'b0;
      wrAddr <= 4'h0;
      wrData <= 8'h00;
      for (int i = 0; i < 16; i++)
        regs_r[i] <= adcshp_pkg::REG_RESET;
    end else begin
      wrStrobe <= 1'b0;
      if (rise && phase_r == ADCSHP_WR && lastBit) begin
        wrStrobe <= 1'b1;
        wrAddr <= addr_r;
        wrData <= commByte;
        regs_r[addr_r] <= commByte;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      shiftOut_r <= 24'h000000;
    else if (rise && phase_r == ADCSHP_COMM &&
      bitCnt_r == adcshp_pkg::LEN_8 - 5'h01)
      shiftOut_r <= rdVal;
    else if (fall && phase_r == ADCSHP_RD)
      shiftOut_r <= {shiftOut_r[22:0], 1'b0};
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !active) begin
      link.misoOut <= 1'b1;
      link.misoOeN <= 1'b1;
    end else if (fall && phase_r == ADCSHP_RD) begin
      link.misoOut <= shiftOut_r[23];
      link.misoOeN <= 1'b0;
    end else if (phase_r != ADCSHP_RD) begin
      link.misoOut <= 1'b1;
      link.misoOeN <= 1'b1;
    end
  end

  assign rdMain = rise && phase_r == ADCSHP_COMM &&
    bitCnt_r == adcshp_pkg::LEN_8 - 5'h01 &&
    commByte[adcshp_pkg::COMM_RD_BIT] &&
    commByte[3:0] == adcshp_pkg::ADDR_MAIN_DATA;
  assign rdAux = rise && phase_r == ADCSHP_COMM &&
    bitCnt_r == adcshp_pkg::LEN_8 - 5'h01 &&
    commByte[adcshp_pkg::COMM_RD_BIT] &&
    commByte[3:0] == adcshp_pkg::ADDR_AUX_DATA;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mainFlag <= 1'b0;
      auxFlag <= 1'b0;
      mainHold_r <= 24'h000000;
      auxHold_r <= 16'h0000;
    end else begin
      if (mainValid) begin
        mainFlag <= 1'b1;
        mainHold_r <= mainData;
      end else if (rdMain) begin
        mainFlag <= 1'b0;
      end
      if (auxValid) begin
        auxFlag <= 1'b1;
        auxHold_r <= auxData;
      end else if (rdAux) begin
        auxFlag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      link.rdyN <= 1'b1;
    else
      link.rdyN <= !(mainFlag || auxFlag);
  end
endmodule
`default_nettype wire

// ---- adcshp_host.sv ----
// Host end: command FIFO and serial master of the converter port.
`timescale 1ns/100ps
`default_nettype none
module adcshp_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic inValid, // write request
  output logic inReady, // room available
  input wire logic [WIDTH-1:0] inData, // write data
  output logic outValid, // data available
  input wire logic outReady, // drain request
  output logic [WIDTH-1:0] outData // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r, rp_r;
  logic full, empty;
  assign empty = wp_r == rp_r;
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem_r[rp_r[AW-1:0]];
  always_ff @(posedge clk_sys) begin
    if (inValid && !full)
      mem_r[wp_r[AW-1:0]] <= inData;
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (inValid && !full)
        wp_r <= wp_r + 1'b1;
      if (outReady && !empty)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule

module adcshp_host (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // synchronous reset, active low
  adcshp_if.host link, // serial link
  input wire logic cmdValid, // command offered
  output logic cmdReady, // command FIFO has room
  input wire logic [7:0] cmdComm, // communications byte
  input wire logic [1:0] cmdBytes, // data bytes, 1 to 3
  input wire logic [23:0] cmdData, // write data, left aligned
  output logic rdValid, // read data pulse
  output logic [23:0] rdData, // read data, right aligned
  output logic readyLvl // device ready, active high
);
  typedef enum {ADCSHP_IDLE, ADCSHP_SETUP, ADCSHP_LOW, ADCSHP_HIGH,
    ADCSHP_GAP} adcshp_hstate_t;
  adcshp_hstate_t st_r;
  logic headValid, pop;
  logic [adcshp_pkg::CMD_W-1:0] head;
  logic [31:0] shOut_r;
  logic [23:0] shIn_r;
  logic [5:0] bitCnt_r, total_r;
  logic [4:0] div_r;
  logic halfTick;
  logic isRead_r;
  logic [2:0] misoSync_r, rdySync_r;

  adcshp_fifo #(.WIDTH(adcshp_pkg::CMD_W), .DEPTH(adcshp_pkg::CMD_DEPTH))
    u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .inValid(cmdValid),
    .inReady(cmdReady),
    .inData({cmdComm, cmdBytes, cmdData}),
    .outValid(headValid),
    .outReady(pop),
    .outData(head)
  );

  assign pop = st_r == ADCSHP_IDLE && headValid;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      misoSync_r <= 3'h7;
      rdySync_r <= 3'h7;
      readyLvl <= 1'b0;
    end else begin
      misoSync_r <= {misoSync_r[1:0], link.misoLine};
      rdySync_r <= {rdySync_r[1:0], link.rdyN};
      if (rdySync_r[1] == rdySync_r[2])
        readyLvl <= !rdySync_r[2];
    end
  end

  // Half-period enable; the divider restarts with every frame so that the
  // lead-in and each half of the serial clock have their full length.
  always_ff @(posedge clk_sys) begin
    if (!reset_n || st_r == ADCSHP_IDLE || halfTick)
      div_r <= 5'h00;
    else
      div_r <= div_r + 5'h01;
  end
  assign halfTick = div_r == 5'(adcshp_pkg::SCLK_HALF_CYC - 1);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_r <= ADCSHP_IDLE;
      link.sclk <= 1'b1;
      link.csN <= 1'b1;
      link.mosi <= 1'b1;
      bitCnt_r <= 6'h00;
      total_r <= 6'h00;
      shOut_r <= 32'h00000000;
      shIn_r <= 24'h000000;
      isRead_r <= 1'b0;
      rdValid <= 1'b0;
      rdData <= 24'h000000;
    end else begin
      rdValid <= 1'b0;
      case (st_r)
        ADCSHP_IDLE: begin
          if (headValid) begin
            shOut_r <= {head[33:26], head[23:0]};
            isRead_r <= head[26 + adcshp_pkg::COMM_RD_BIT];
            total_r <= 6'(adcshp_pkg::COMM_BITS) + {1'b0, head[25:24], 3'h0};
            bitCnt_r <= 6'h00;
            shIn_r <= 24'h000000;
            link.csN <= 1'b0;
            st_r <= ADCSHP_SETUP;
          end
        end
        ADCSHP_SETUP: begin
          if (halfTick) begin
            link.sclk <= 1'b0;
            link.mosi <= shOut_r[31];
            shOut_r <= {shOut_r[30:0], 1'b1};
            st_r <= ADCSHP_LOW;
          end
        end
        ADCSHP_LOW: begin
          if (halfTick) begin
            link.sclk <= 1'b1;
            if (bitCnt_r >= 6'(adcshp_pkg::COMM_BITS))
              shIn_r <= {shIn_r[22:0], misoSync_r[2]};
            bitCnt_r <= bitCnt_r + 6'h01;
            st_r <= ADCSHP_HIGH;
          end
        end
        ADCSHP_HIGH: begin
          if (halfTick) begin
            if (bitCnt_r == total_r) begin
              link.csN <= 1'b1;
              link.mosi <= 1'b1;
              rdValid <= isRead_r;
              rdData <= shIn_r;
              st_r <= ADCSHP_GAP;
            end else begin
              link.sclk <= 1'b0;
              link.mosi <= shOut_r[31];
              shOut_r <= {shOut_r[30:0], 1'b1};
              st_r <= ADCSHP_LOW;
            end
          end
        end
        ADCSHP_GAP: begin
          if (div_r == 5'(adcshp_pkg::CS_GAP_CYC - 1))
            st_r <= ADCSHP_IDLE;
        end
        default: begin
          st_r <= ADCSHP_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- adcshp_link_checker.sv ----
// Concurrent checks on the serial link between the host and device ends.
`timescale 1ns/100ps
`default_nettype none
module adcshp_link_checker (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic sclk, // serial clock
  input wire logic csN, // frame select, active low
  input wire logic mosi, // host data
  input wire logic misoOut, // device data
  input wire logic misoOeN, // device drive enable, low drives
  input wire logic rdyN // ready pin, active low
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  a_idle_clock_high: assert property (csN |-> sclk)
    else $error("serial clock low outside a frame");
  a_frame_lead_in: assert property ($fell(csN) |-> sclk [*8])
    else $error("serial clock left high too briefly at frame start");
  a_low_half_len: assert property ($fell(sclk) |-> !sclk [*8] ##1 sclk)
    else $error("serial clock low half has the wrong length");
  a_mosi_held_high: assert property (
    !csN && !$past(csN) && sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while the clock was high");
  a_miso_moves_low: assert property (
    !misoOeN && !$past(misoOeN) && $changed(misoOut) |-> !sclk)
    else $error("device data moved while the clock was high");
  a_drive_starts_low: assert property (
    $fell(misoOeN) |-> !sclk && !csN)
    else $error("device began driving outside a read shift");
  a_release_deselect: assert property (csN [*6] |-> misoOeN)
    else $error("device drives the data line while deselected");
  a_ready_rise_framed: assert property ($rose(rdyN) |-> !csN)
    else $error("ready pin cleared outside a read frame");
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench joining the host and device ends over the link.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) cmp(32'(g), 32'(e))
module tb;
  logic clk_sys = 1'b0;
  logic reset_n;
  logic mainValid = 1'b0;
  logic auxValid = 1'b0;
  logic cmdValid = 1'b0;
  logic [23:0] mainData = 24'h0;
  logic [23:0] cmdData = 24'h0;
  logic [15:0] auxData = 16'h0;
  logic [7:0] cmdComm = 8'h0;
  logic [1:0] cmdBytes = 2'h0;
  logic [23:0] rdData;
  logic [7:0] wrData;
  logic [3:0] wrAddr;
  logic wrStrobe, mainFlag, auxFlag, cmdReady, rdValid, readyLvl;
  logic [23:0] expQ[$];
  logic [11:0] wrQ[$];
  logic [7:0] regs [16];
  logic [23:0] mainD = 24'h0;
  logic [15:0] auxD = 16'h0;
  logic mF = 1'b0;
  logic aF = 1'b0;
  logic sawFull = 1'b0;
  logic [3:0] a;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  adcshp_if link ();
  adcshp_device adcshp_device_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .link(link.dev), .mainValid(mainValid), .mainData(mainData),
    .auxValid(auxValid), .auxData(auxData), .wrStrobe(wrStrobe),
    .wrAddr(wrAddr), .wrData(wrData), .mainFlag(mainFlag),
    .auxFlag(auxFlag));
  adcshp_host adcshp_host_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .link(link.host), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdComm(cmdComm), .cmdBytes(cmdBytes), .cmdData(cmdData),
    .rdValid(rdValid), .rdData(rdData), .readyLvl(readyLvl));
  adcshp_link_checker adcshp_link_checker_inst (.clk_sys(clk_sys),
    .reset_n(reset_n), .sclk(link.sclk), .csN(link.csN), .mosi(link.mosi),
    .misoOut(link.misoOut), .misoOeN(link.misoOeN), .rdyN(link.rdyN));
  always #5 clk_sys = ~clk_sys;

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    expQ.delete();
    wrQ.delete();
    regs = '{default: 8'h00};
    mF = 1'b0;
    aF = 1'b0;
  endtask

  task automatic send(input logic [7:0] c, input logic [1:0] b,
      input logic [23:0] d);
    cmdValid <= 1'b1;
    cmdComm <= c;
    cmdBytes <= b;
    cmdData <= d;
    @(posedge clk_sys);
    while (cmdReady !== 1'b1) begin
      sawFull = 1'b1;
      @(posedge clk_sys);
    end
  endtask

  // Expected read word of one address, right aligned as the host returns it.
  function automatic logic [23:0] exp_read(input logic [3:0] ad);
    if (ad == adcshp_pkg::ADDR_STATUS) return {22'h0, aF, mF};
    if (ad == adcshp_pkg::ADDR_MAIN_DATA) return mainD;
    if (ad == adcshp_pkg::ADDR_AUX_DATA) return {8'h00, auxD};
    return {16'h0, regs[ad]};
  endfunction

  // The model follows each access in issue order, so bursts stay exact.
  task automatic access(input logic rd, input logic [3:0] ad,
      input logic [23:0] d);
    logic [1:0] nb;
    nb = 2'h1;
    if (ad == adcshp_pkg::ADDR_MAIN_DATA) nb = 2'h3;
    if (ad == adcshp_pkg::ADDR_AUX_DATA) nb = 2'h2;
    if (!rd) begin
      wrQ.push_back({ad, d[23:16]});
      regs[ad] = d[23:16];
    end else begin
      expQ.push_back(exp_read(ad));
      if (nb == 2'h3) mF = 1'b0;
      if (nb == 2'h2) aF = 1'b0;
    end
    send({1'b0, rd, 2'b00, ad}, nb, d);
  endtask

  task automatic result(input logic m, input logic [23:0] d);
    if (m) begin
      mainValid <= 1'b1;
      mainData <= d;
      mainD = d;
      mF = 1'b1;
    end else begin
      auxValid <= 1'b1;
      auxData <= d[15:0];
      auxD = d[15:0];
      aF = 1'b1;
    end
    @(posedge clk_sys);
    mainValid <= 1'b0;
    auxValid <= 1'b0;
  endtask

  task automatic check_idle();
    repeat (12) @(posedge clk_sys);
    `CHK(mainFlag, mF);
    `CHK(auxFlag, aF);
    `CHK(link.rdyN, !(mF || aF));
    `CHK(readyLvl, mF || aF);
    `CHK({link.csN, link.sclk, link.misoOeN, link.misoLine}, 4'hf);
  endtask

  task automatic drain();
    cmdValid <= 1'b0;
    for (int i = 0; i < 20000 && expQ.size() + wrQ.size() != 0; i++) begin
      @(posedge clk_sys);
    end
    // A transfer that never completed counts against the run.
    `CHK(expQ.size() + wrQ.size(), 0);
    repeat (24) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) cmp(32'h1, 32'h0);
      else `CHK(rdData, expQ.pop_front());
    end
    if (wrStrobe === 1'b1) begin
      if (wrQ.size() == 0) cmp(32'h1, 32'h0);
      else `CHK({wrAddr, wrData}, wrQ.pop_front());
    end
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(32'hc61ccda0));
    do_reset();
    check_idle();
    $display("test reset done");
    result(1'b1, $urandom);
    check_idle();
    result(1'b0, $urandom);
    check_idle();
    access(1'b1, adcshp_pkg::ADDR_STATUS, $urandom);
    access(1'b1, adcshp_pkg::ADDR_MAIN_DATA, $urandom);
    access(1'b1, adcshp_pkg::ADDR_AUX_DATA, $urandom);
    drain();
    check_idle();
    $display("test results done");
    for (int i = 0; i < 12; i++) begin
      a = 4'($urandom_range(1, 12));
      if (a >= 4'h4) a = a + 4'h2;
      access(1'b0, a, (i < 2) ? {{8{i[0]}}, 16'h0} : 24'($urandom));
      access(1'b1, a, $urandom);
      if (i % 4 == 0) access(1'b1, adcshp_pkg::ADDR_STATUS, $urandom);
    end
    drain();
    `CHK(sawFull, 1'b1);
    check_idle();
    $display("test burst done");
    result(1'b1, $urandom);
    access(1'b0, 4'h2, 24'h5a0000);
    cmdValid <= 1'b0;
    repeat (200) @(posedge clk_sys);
    do_reset();
    check_idle();
    access(1'b1, 4'h2, $urandom);
    drain();
    $display("test reset mid frame done");
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire
